// *** logic/cdd_decoder.sv ***
// instruction decoder and memories of the character display controller
`include "cdd_map.svh"
`default_nettype none
module cdd_decoder
	import cdd_pkg::*;
(
	input wire logic mclk, // 25 MHz clock
	input wire logic rst, // async reset
	input wire logic cmd_data_select, // 1 = data, 0 = instruction
	input wire logic [7:0] wdata, // host write byte
	input wire logic wr_stb, // write strobe (transfer_direction low)
	input wire logic rd_stb, // read strobe (transfer_direction high)
	output logic [7:0] rdata, // read answer, two cycles after rd_stb
	output logic rvalid, // read answer valid
	input wire logic rready, // receiver accepts answer
	output logic busy_indicator, // internal operation running
	output logic [6:0] location_pointer, // address counter
	output logic [6:0] disp_shift, // display shift amount
	output logic [2:0] disp_ctl, // on, cursor, blink
	output logic [4:0] func_cfg, // width, lines, font, table
	output logic graphic_mode, // graphic mode
	output logic power_on // internal supply on
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	localparam int CLR_CYC = `CDD_CLEAR_CYC;
	logic [7:0] text_buffer_memory [`CDD_TEXT_DEPTH];
	logic [7:0] glyph_memory [`CDD_GLYPH_DEPTH];
	cdd_state_t st_r, st_nxt;
	logic [17:0] cnt_r, cnt_nxt;
	logic [6:0] ptr_r;
	logic glyph_sel_r;
	logic step_up_r;
	logic shift_en_r;
	cdd_disp_t disp_r;
	logic [4:0] fset_r;
	logic gfx_r;
	logic pwr_r;
	logic [6:0] shift_r;
	logic busy_r;
	logic [6:0] clr_idx_r;
	logic step_pend_r;

	function automatic logic [6:0] step(input logic [6:0] p, input logic up);
		step = up ? p + 7'h01 : p - 7'h01;
	endfunction : step

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire idle = (st_r == CDD_IDLE);
	wire iw = wr_stb && !cmd_data_select && idle;
	wire dw = wr_stb && cmd_data_select && idle;
	wire sr = rd_stb && !cmd_data_select;
	wire skid_rdy;
	wire dr = rd_stb && cmd_data_select && idle && skid_rdy;
	wire i_clr = iw && (wdata == 8'h01);
	wire i_home = iw && (wdata[7:1] == 7'h01);
	wire i_entry = iw && (wdata[7:2] == 6'h01);
	wire i_disp = iw && (wdata[7:3] == 5'h01);
	wire i_shift = iw && (wdata[7:4] == 4'h1) && (wdata[1:0] == 2'h0);
	wire i_mode = iw && (wdata[7:4] == 4'h1) && (wdata[1:0] == 2'h3);
	wire i_fset = iw && (wdata[7:5] == 3'h1);
	wire i_cga = iw && (wdata[7:6] == 2'h1);
	wire i_dda = iw && wdata[7];
	wire [7:0] mem_rd = glyph_sel_r ? glyph_memory[ptr_r[5:0]]
		: text_buffer_memory[ptr_r];
	wire [7:0] stat_byte = {busy_r, ptr_r};
	cdd_word_t ans;
	assign ans.data = sr ? stat_byte : mem_rd;
	assign ans.is_data = !sr;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			CDD_IDLE: begin
				if (i_clr) begin
					st_nxt = CDD_CLEAR;
					cnt_nxt = 18'(CLR_CYC - 1);
				end else if (iw) begin
					st_nxt = CDD_WAIT;
					cnt_nxt = 18'(`CDD_INSTR_CYC - 1);
				end else if (dw || dr) begin
					st_nxt = CDD_WAIT;
					cnt_nxt = 18'(`CDD_DATA_CYC - 1);
				end
			end
			CDD_WAIT, CDD_CLEAR: begin
				if (cnt_r == 18'h0)
					st_nxt = CDD_IDLE;
				else
					cnt_nxt = cnt_r - 18'h1;
			end
			default: st_nxt = CDD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= CDD_IDLE;
			cnt_r <= 18'h0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= (st_nxt != CDD_IDLE);
		end
	end

	// ---------------------------------------------------------------
	// clear sweep over text memory
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			clr_idx_r <= 7'h00;
		else if (i_clr)
			clr_idx_r <= 7'h00;
		else if (st_r == CDD_CLEAR && clr_idx_r != 7'h7F)
			clr_idx_r <= clr_idx_r + 7'h01;
	end

	always_ff @(posedge mclk) begin
		if (st_r == CDD_CLEAR)
			text_buffer_memory[clr_idx_r] <= `CDD_BLANK;
		else if (dw && !glyph_sel_r)
			text_buffer_memory[ptr_r] <= wdata;
		if (dw && glyph_sel_r)
			glyph_memory[ptr_r[5:0]] <= wdata;
	end

	// ---------------------------------------------------------------
	// pointer and settings
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ptr_r <= 7'h00;
			glyph_sel_r <= 1'b0;
			step_pend_r <= 1'b0;
			shift_r <= 7'h00;
		end else begin
			if (i_clr || i_home) begin
				ptr_r <= 7'h00;
				glyph_sel_r <= 1'b0;
				shift_r <= 7'h00;
			end else if (i_cga) begin
				ptr_r <= {1'b0, wdata[5:0]};
				glyph_sel_r <= 1'b1;
			end else if (i_dda) begin
				ptr_r <= wdata[6:0];
				glyph_sel_r <= 1'b0;
			end else if (i_shift) begin
				if (wdata[3])
					shift_r <= step(shift_r, wdata[2]);
				else
					ptr_r <= step(ptr_r, wdata[2]);
			end
			if (dw || dr)
				step_pend_r <= 1'b1;
			else if (step_pend_r && st_nxt == CDD_IDLE) begin
				step_pend_r <= 1'b0;
				ptr_r <= glyph_sel_r ? {1'b0, 6'(step(ptr_r, step_up_r))}
					: step(ptr_r, step_up_r);
				if (shift_en_r)
					shift_r <= step(shift_r, step_up_r);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			step_up_r <= 1'b1;
			shift_en_r <= 1'b0;
			disp_r <= '0;
			fset_r <= `CDD_FSET_RST;
			gfx_r <= 1'b0;
			pwr_r <= 1'b0;
		end else begin
			if (i_entry) begin
				step_up_r <= wdata[1];
				shift_en_r <= wdata[0];
			end
			if (i_disp)
				disp_r <= wdata[2:0];
			if (i_mode) begin
				gfx_r <= wdata[3];
				pwr_r <= wdata[2];
			end
			if (i_fset)
				fset_r <= wdata[4:0];
		end
	end

	// ---------------------------------------------------------------
	// read answers through the buffer
	// ---------------------------------------------------------------
	cdd_word_t out_w;
	wire out_v;
	cdd_skid u_skid (
		.mclk(mclk),
		.rst(rst),
		.in_valid(sr || dr),
		.in_ready(skid_rdy),
		.in_word(ans),
		.out_valid(out_v),
		.out_ready(rready || !rvalid),
		.out_word(out_w)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
			busy_indicator <= 1'b0;
			location_pointer <= 7'h00;
			disp_shift <= 7'h00;
			disp_ctl <= 3'h0;
			func_cfg <= `CDD_FSET_RST;
			graphic_mode <= 1'b0;
			power_on <= 1'b0;
		end else begin
			if (rready || !rvalid) begin
				rvalid <= out_v;
				rdata <= out_w.data;
			end
			busy_indicator <= busy_r;
			location_pointer <= ptr_r;
			disp_shift <= shift_r;
			disp_ctl <= disp_r;
			func_cfg <= fset_r;
			graphic_mode <= gfx_r;
			power_on <= pwr_r;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_clear_issue;
		i_clr;
	endsequence
	sequence s_instr_take;
		iw && !i_clr;
	endsequence
	sequence s_text_up;
		dw && !glyph_sel_r && step_up_r;
	endsequence
	sequence s_text_down;
		dw && !glyph_sel_r && !step_up_r;
	endsequence
	sequence s_glyph_write;
		dw && glyph_sel_r;
	endsequence
	// answer path empty, receiver ready for two edges
	sequence s_status_ask;
		sr && !out_v && rready ##1 rready;
	endsequence
	sequence s_data_ask;
		dr && !out_v && rready ##1 rready;
	endsequence

	a_clear_ptr: assert property (
		@(posedge mclk) disable iff (rst)
		s_clear_issue |=> (ptr_r == 7'h00) && busy_r)
		else $error("clear did not zero pointer");
	a_clear_blank: assert property (
		@(posedge mclk) disable iff (rst)
		s_clear_issue |-> ##2 text_buffer_memory[0] == `CDD_BLANK)
		else $error("clear did not blank text");
	a_home_ptr: assert property (
		@(posedge mclk) disable iff (rst)
		i_home |=> ptr_r == 7'h00 && shift_r == 7'h00 && !glyph_sel_r)
		else $error("home did not reset pointer");
	a_entry_latch: assert property (
		@(posedge mclk) disable iff (rst)
		i_entry |=> step_up_r == $past(wdata[1])
			&& shift_en_r == $past(wdata[0]))
		else $error("entry bits not latched");
	a_disp_latch: assert property (
		@(posedge mclk) disable iff (rst)
		i_disp |=> disp_r == $past(wdata[2:0]))
		else $error("display bits not latched");
	a_shift_cursor: assert property (
		@(posedge mclk) disable iff (rst)
		i_shift && !wdata[3] && wdata[2] |=> $stable(shift_r)
			&& ptr_r == $past(ptr_r) + 7'h01)
		else $error("cursor move went wrong");
	a_shift_display: assert property (
		@(posedge mclk) disable iff (rst)
		i_shift && wdata[3] |=> $stable(ptr_r) && shift_r != $past(shift_r))
		else $error("display shift went wrong");
	a_mode_latch: assert property (
		@(posedge mclk) disable iff (rst)
		i_mode |=> gfx_r == $past(wdata[3]) && pwr_r == $past(wdata[2]))
		else $error("mode bits not latched");
	a_fset_latch: assert property (
		@(posedge mclk) disable iff (rst)
		i_fset |=> fset_r == $past(wdata[4:0]))
		else $error("function bits not latched");
	a_glyph_load: assert property (
		@(posedge mclk) disable iff (rst)
		i_cga |=> glyph_sel_r && ptr_r == {1'b0, $past(wdata[5:0])})
		else $error("glyph address not loaded");
	a_text_load: assert property (
		@(posedge mclk) disable iff (rst)
		i_dda |=> !glyph_sel_r && ptr_r == $past(wdata[6:0]))
		else $error("text address not loaded");
	a_busy_block: assert property (
		@(posedge mclk) disable iff (rst)
		busy_r && wr_stb |=> $stable(fset_r) && $stable(disp_r))
		else $error("instruction taken while busy");
	a_busy_length: assert property (
		@(posedge mclk) disable iff (rst)
		s_instr_take |=> busy_r [*8] ##1 busy_r ##1 busy_r ##1 !busy_r)
		else $error("busy time wrong");
	a_step_up: assert property (
		@(posedge mclk) disable iff (rst)
		s_text_up |-> ##11 ptr_r == $past(ptr_r, 11) + 7'h01)
		else $error("pointer did not step up");
	a_step_down: assert property (
		@(posedge mclk) disable iff (rst)
		s_text_down |-> ##11 ptr_r == $past(ptr_r, 11) - 7'h01)
		else $error("pointer did not step down");
	a_text_store: assert property (
		@(posedge mclk) disable iff (rst)
		dw && !glyph_sel_r |=> text_buffer_memory[$past(ptr_r)] == $past(wdata))
		else $error("text byte not stored");
	a_glyph_store: assert property (
		@(posedge mclk) disable iff (rst)
		s_glyph_write |=> glyph_memory[$past(ptr_r[5:0])] == $past(wdata))
		else $error("glyph byte not stored");
	a_status_byte: assert property (
		@(posedge mclk) disable iff (rst)
		s_status_ask |=> rvalid && rdata == $past({busy_r, ptr_r}, 2))
		else $error("status answer wrong");
	a_data_read: assert property (
		@(posedge mclk) disable iff (rst)
		s_data_ask |=> rvalid && rdata == $past(mem_rd, 2))
		else $error("data answer wrong");
endmodule : cdd_decoder
`default_nettype wire

// *** logic/cdd_map.svh ***
// register layout, reset values and timing counts of the command decoder
`ifndef CDD_MAP_SVH
`define CDD_MAP_SVH
`define CDD_CLK_HZ 25000000
`define CDD_CLEAR_NS 6200000
`define CDD_CLEAR_CYC ((`CDD_CLEAR_NS / 40))
`define CDD_INSTR_CYC 10
`define CDD_DATA_CYC 10
`define CDD_TEXT_DEPTH 128
`define CDD_GLYPH_DEPTH 64
`define CDD_BLANK 8'h20
`define CDD_FSET_RST 5'h10
`define CDD_OFF_CMD 2'h0
`define CDD_OFF_DATA 2'h1
`endif

// *** logic/cdd_pkg.sv ***
// types shared by the command decoder files
`default_nettype none
package cdd_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic is_data;
	} cdd_word_t;
	typedef enum logic [1:0] {
		CDD_IDLE,
		CDD_WAIT,
		CDD_CLEAR
	} cdd_state_t;
	typedef struct packed {
		logic disp_on;
		logic cursor_on;
		logic blink_on;
	} cdd_disp_t;
endpackage : cdd_pkg
`default_nettype wire

// *** logic/cdd_skid.sv ***
// two-entry buffer for read answers
`default_nettype none
module cdd_skid
	import cdd_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst, // async reset
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	input wire cdd_word_t in_word, // word in
	output logic out_valid, // word held
	input wire logic out_ready, // drain
	output cdd_word_t out_word // word out
);
	cdd_word_t mem_r [2];
	logic wp_r;
	logic rp_r;
	logic [1:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_word = mem_r[rp_r];
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_word;
				wp_r <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : cdd_skid
`default_nettype wire

// *** verif/cdd_host.sv ***
// host bus model that drives the command decoder
`default_nettype none
module cdd_host (
	input wire logic mclk, // bus clock
	output var logic cmd_data_select, // 1 data, 0 instruction
	output var logic [7:0] wdata, // write byte
	output var logic wr_stb, // write strobe
	output var logic rd_stb, // read strobe
	output var logic rready, // answer accepted
	input wire logic [7:0] rdata, // read answer
	input wire logic rvalid // answer held
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_data_select = 1'b0;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		rready = 1'b1;
	end
	task automatic wr(input logic cd, input logic [7:0] b);
		@(posedge mclk);
		cmd_data_select <= cd;
		wdata <= b;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		wdata <= ~b;
	endtask : wr
	// answer taken at the edge where rvalid is seen high, bounded wait
	task automatic rd(input logic cd, output logic [7:0] d);
		d = 8'hXX;
		@(posedge mclk);
		cmd_data_select <= cd;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			if (rvalid === 1'b1) begin
				d = rdata;
				break;
			end
		end
	endtask : rd
	// status polled until idle, bounded
	task automatic poll(output logic [7:0] s);
		for (int i = 0; i < 40; i++) begin
			rd(1'b0, s);
			if (s[7] === 1'b0)
				break;
		end
	endtask : poll
	task automatic cmd(input logic [7:0] b);
		logic [7:0] s;
		poll(s);
		wr(1'b0, b);
	endtask : cmd
	task automatic stall(input logic r);
		@(posedge mclk);
		rready <= r;
	endtask : stall
endmodule : cdd_host
`default_nettype wire

// *** verif/tb_cdd_decoder.sv ***
// self-checking bench of the command decoder
`default_nettype none
module tb_cdd_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst;
	logic [7:0] s;
	wire logic cds, wr_stb, rd_stb, rready, rvalid, busy, gm, pw;
	wire logic [7:0] wdata, rdata;
	wire logic [6:0] ptr, shift;
	wire logic [2:0] ctl;
	wire logic [4:0] fcfg;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	cdd_decoder DUT (.mclk(mclk), .rst(rst), .cmd_data_select(cds),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.rvalid(rvalid), .rready(rready), .busy_indicator(busy),
		.location_pointer(ptr), .disp_shift(shift), .disp_ctl(ctl),
		.func_cfg(fcfg), .graphic_mode(gm), .power_on(pw));
	cdd_host host (.mclk(mclk), .cmd_data_select(cds), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rready(rready),
		.rdata(rdata), .rvalid(rvalid));
	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_addr();
		host.cmd(8'hC5);
		host.poll(s);
		chk(s, 8'h45);
		host.cmd(8'h4A);
		host.poll(s);
		chk(s, 8'h0A);
		$display("addr test done");
	endtask : t_addr
	task automatic t_data();
		host.cmd(8'h06);
		host.cmd(8'h90);
		host.poll(s);
		host.wr(1'b1, 8'hA1);
		host.poll(s);
		host.wr(1'b1, 8'hB2);
		host.poll(s);
		chk(s, 8'h12);
		host.cmd(8'h90);
		host.poll(s);
		host.rd(1'b1, s);
		chk(s, 8'hA1);
		host.poll(s);
		host.rd(1'b1, s);
		chk(s, 8'hB2);
		host.cmd(8'h04);
		host.cmd(8'hA0);
		host.poll(s);
		host.wr(1'b1, 8'hC3);
		host.poll(s);
		chk(s, 8'h1F);
		host.cmd(8'h45);
		host.poll(s);
		host.wr(1'b1, 8'h5A);
		host.cmd(8'h45);
		host.poll(s);
		host.rd(1'b1, s);
		chk(s, 8'h5A);
		$display("data test done");
	endtask : t_data
	task automatic t_cfg();
		chk({3'h0, fcfg}, 8'h10);
		host.cmd(8'h0F);
		host.cmd(8'h3B);
		host.poll(s);
		chk({5'h0, ctl}, 8'h07);
		chk({3'h0, fcfg}, 8'h1B);
		host.cmd(8'h0A);
		host.cmd(8'h1B);
		host.poll(s);
		chk({5'h0, ctl}, 8'h02);
		chk({6'h0, gm, pw}, 8'h02);
		host.cmd(8'h17);
		host.poll(s);
		chk({6'h0, gm, pw}, 8'h01);
		$display("config test done");
	endtask : t_cfg
	task automatic t_shift();
		host.cmd(8'h80);
		host.cmd(8'h14);
		host.cmd(8'h1C);
		host.poll(s);
		chk(s, 8'h01);
		chk({1'b0, shift}, 8'h01);
		host.cmd(8'h02);
		host.poll(s);
		chk(s, 8'h00);
		chk({1'b0, shift}, 8'h00);
		$display("shift test done");
	endtask : t_shift
	task automatic t_busy();
		host.cmd(8'h91);
		host.wr(1'b0, 8'hB3);
		host.poll(s);
		chk(s, 8'h11);
		$display("busy test done");
	endtask : t_busy
	task automatic t_buf();
		int n;
		n = 0;
		host.stall(1'b0);
		host.rd(1'b0, s);
		host.rd(1'b0, s);
		host.rd(1'b0, s);
		repeat (3) @(posedge mclk);
		host.stall(1'b1);
		repeat (5) begin
			#1;
			if (rvalid === 1'b1)
				n++;
			@(posedge mclk);
		end
		chk(n[7:0], 8'h03);
		$display("buffer test done");
	endtask : t_buf
	task automatic t_clear();
		host.cmd(8'h01);
		repeat (40) @(posedge mclk);
		#1;
		chk({7'h0, busy}, 8'h01);
		chk({1'b0, ptr}, 8'h00);
		$display("clear test done");
	endtask : t_clear
	initial begin
		rst = 1'b1;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		t_cfg();
		t_addr();
		t_data();
		t_shift();
		t_busy();
		t_buf();
		t_clear();
		end_sim();
	end
endmodule : tb_cdd_decoder
`default_nettype wire
